// >>> design/fhr_fault_history_recall.v
// Fault history recall: button timing, six-deep history, two-digit display.
// Assumes button and demand inputs synchronous to clk; display active high.
`include "fhr_regs.vh"

module fhr_fault_history_recall #(
  parameter TICK_CYC = `FHR_TICK_CYC, // Cycles per 100 ms hold tick
  parameter DEB_CYC  = `FHR_DEB_CYC   // Cycles of stable button for debounce
) (
  input  wire       clk,          // 10 MHz system clock
  input  wire       rst_b,        // Asynchronous reset, active low
  input  wire       button_in,    // Service button, high while pressed
  input  wire       demand_in,    // Any thermostat demand active
  input  wire [7:0] active_fault, // Active fault code, 0 means none
  input  wire       fault_log,    // One-cycle pulse: log active_fault
  output reg  [6:0] seg_hi_q,     // Tens digit segments g..a
  output reg  [6:0] seg_lo_q,     // Units digit segments g..a
  output wire       standby       // High when in standby mode
);

  localparam ST_IDLE   = 3'd0;
  localparam ST_HOLD   = 3'd1;
  localparam ST_SHOW   = 3'd2;
  localparam ST_END    = 3'd3;
  localparam ST_SHOW88 = 3'd4;

  ////////////////////////////////////////////////////////////////////
  // Hex digit to segments
  function [6:0] hex_seg;
    input [3:0] n;
    begin
      case (n)
        4'h0: hex_seg = 7'h3F;
        4'h1: hex_seg = 7'h06;
        4'h2: hex_seg = 7'h5B;
        4'h3: hex_seg = 7'h4F;
        4'h4: hex_seg = 7'h66;
        4'h5: hex_seg = 7'h6D;
        4'h6: hex_seg = 7'h7D;
        4'h7: hex_seg = 7'h07;
        4'h8: hex_seg = 7'h7F;
        4'h9: hex_seg = 7'h6F;
        4'hA: hex_seg = 7'h77;
        4'hB: hex_seg = 7'h7C;
        4'hC: hex_seg = 7'h39;
        4'hD: hex_seg = 7'h5E;
        4'hE: hex_seg = 7'h79;
        default: hex_seg = 7'h71;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Debounce and 100 ms tick
  reg [17:0] deb_cnt_q;
  reg        btn_q;
  reg        btn_prev_q;
  reg [19:0] tick_cnt_q;
  wire       tick = (tick_cnt_q == TICK_CYC - 1);
  wire       press = btn_q & ~btn_prev_q;
  wire       release_ev = ~btn_q & btn_prev_q;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      deb_cnt_q  <= 18'h00000;
      btn_q      <= 1'b0;
      btn_prev_q <= 1'b0;
      tick_cnt_q <= 20'h00000;
    end
    else
    begin
      btn_prev_q <= btn_q;
      if (button_in == btn_q)
        deb_cnt_q <= 18'h00000;
      else if (deb_cnt_q == DEB_CYC - 1)
      begin
        btn_q     <= button_in;
        deb_cnt_q <= 18'h00000;
      end
      else
        deb_cnt_q <= deb_cnt_q + 18'h00001;
      tick_cnt_q <= tick ? 20'h00000 : tick_cnt_q + 20'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // History: entry 0 newest
  reg [7:0] hist_q [0:`FHR_DEPTH-1];
  reg [2:0] count_q;
  reg [1:0] run_q;
  reg [2:0] state_q;
  reg [7:0] hold_q;
  reg [7:0] timer_q;
  reg [2:0] idx_q;
  reg       clear_req;
  integer   i;

  wire same = (count_q != 3'd0) && (hist_q[0] == active_fault);
  // Log ignored on the clear cycle; clearing wins
  wire do_log = fault_log && (active_fault != 8'h00) && !clear_req
                && !(same && run_q == `FHR_REPEAT_MAX);

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (i = 0; i < `FHR_DEPTH; i = i + 1)
        hist_q[i] <= 8'h00;
      count_q <= 3'd0;
      run_q   <= 2'd0;
    end
    else if (clear_req)
    begin
      count_q <= 3'd0;
      run_q   <= 2'd0;
    end
    else if (do_log)
    begin
      for (i = `FHR_DEPTH - 1; i > 0; i = i - 1)
        hist_q[i] <= hist_q[i-1];
      hist_q[0] <= active_fault;
      if (count_q != `FHR_DEPTH)
        count_q <= count_q + 3'd1;
      run_q <= same ? run_q + 2'd1 : 2'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control
  localparam T_RMIN = `FHR_RECALL_MIN_S * `FHR_TICKS_PER_S;
  localparam T_RMAX = `FHR_RECALL_MAX_S * `FHR_TICKS_PER_S;
  localparam T_CMIN = `FHR_CLEAR_MIN_S * `FHR_TICKS_PER_S;
  localparam T_CMAX = `FHR_CLEAR_MAX_S * `FHR_TICKS_PER_S;

  wire in_recall = (hold_q >= T_RMIN) && (hold_q < T_RMAX);
  wire in_clear  = (hold_q >= T_CMIN) && (hold_q < T_CMAX);

  always @*
    clear_req = (state_q == ST_HOLD) && release_ev && in_clear;

  assign standby = (state_q == ST_IDLE) && !demand_in;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      hold_q  <= 8'h00;
      timer_q <= 8'h00;
      idx_q   <= 3'd0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          hold_q <= 8'h00;
          if (press && !demand_in)
            state_q <= ST_HOLD;
        end
        ST_HOLD:
        begin
          // Saturate so very long holds stay past clear window
          if (tick && hold_q != 8'hFF)
            hold_q <= hold_q + 8'h01;
          if (release_ev)
          begin
            idx_q   <= 3'd0;
            timer_q <= 8'h00;
            if (in_recall)
              state_q <= (count_q == 3'd0) ? ST_END : ST_SHOW;
            else if (in_clear)
              state_q <= ST_SHOW88;
            else
              state_q <= ST_IDLE;
          end
        end
        ST_SHOW:
          if (press)
          begin
            timer_q <= 8'h00;
            if (idx_q + 3'd1 >= count_q)
              state_q <= ST_END;
            else
              idx_q <= idx_q + 3'd1;
          end
        ST_END:
          if (tick)
          begin
            if (timer_q == `FHR_END_TICKS - 1)
              state_q <= ST_IDLE;
            else
              timer_q <= timer_q + 8'h01;
          end
        ST_SHOW88:
          if (tick)
          begin
            if (timer_q == `FHR_SHOW88_TICKS - 1)
              state_q <= ST_IDLE;
            else
              timer_q <= timer_q + 8'h01;
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Blink phase and display
  reg [2:0] blink_cnt_q;
  reg       blink_q;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      blink_cnt_q <= 3'd0;
      blink_q     <= 1'b0;
    end
    else if (tick)
    begin
      if (blink_cnt_q == `FHR_BLINK_TICKS - 1)
      begin
        blink_cnt_q <= 3'd0;
        blink_q     <= ~blink_q;
      end
      else
        blink_cnt_q <= blink_cnt_q + 3'd1;
    end
  end

  reg [6:0] hi_d;
  reg [6:0] lo_d;
  reg [7:0] code;

  always @*
  begin
    hi_d = `FHR_SEG_OFF;
    lo_d = `FHR_SEG_OFF;
    code = hist_q[idx_q];
    case (state_q)
      ST_HOLD:
        if (in_recall)
        begin
          hi_d = `FHR_SEG_DASH;
          lo_d = `FHR_SEG_DASH;
        end
        else if (in_clear && blink_q)
        begin
          hi_d = `FHR_SEG_DASH;
          lo_d = `FHR_SEG_DASH;
        end
      ST_SHOW:
      begin
        hi_d = hex_seg(code[7:4]);
        lo_d = hex_seg(code[3:0]);
      end
      ST_END:
        if (blink_q)
        begin
          hi_d = `FHR_SEG_DASH;
          lo_d = `FHR_SEG_DASH;
        end
      ST_SHOW88:
      begin
        hi_d = `FHR_SEG_EIGHT;
        lo_d = `FHR_SEG_EIGHT;
      end
      default:
        if (active_fault != 8'h00)
        begin
          hi_d = hex_seg(active_fault[7:4]);
          lo_d = hex_seg(active_fault[3:0]);
        end
    endcase
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seg_hi_q <= `FHR_SEG_OFF;
      seg_lo_q <= `FHR_SEG_OFF;
    end
    else
    begin
      seg_hi_q <= hi_d;
      seg_lo_q <= lo_d;
    end
  end

endmodule // fhr_fault_history_recall

// >>> design/fhr_regs.vh
// Constants for the fault history recall controller.
// Assumes a 10 MHz system clock and synchronous inputs.
// How it works
// - Keep last six fault codes for recall
// - Recall or clear only in standby
// - Show two dashes while held 2-5 s
// - Release in recall window shows newest fault
// - Each further press shows next older entry
// - After last entry blink dashes, standby
// - Blink dashes while held 10-15 s
// - Release in clear window erases, shows 88
// - Hold under 2 s does nothing
// - Release between 5 and 10 s does nothing
// - Hold over 15 s cancels clear
// - Repeated fault stored at most three times
// - Otherwise, in idle state, show active fault code
`ifndef FHR_REGS_VH
`define FHR_REGS_VH
`define FHR_CLK_HZ        10000000
`define FHR_TICK_MS       100
`define FHR_TICK_CYC      ((`FHR_CLK_HZ / 1000) * `FHR_TICK_MS)
`define FHR_DEB_MS        20
`define FHR_DEB_CYC       ((`FHR_CLK_HZ / 1000) * `FHR_DEB_MS)
`define FHR_RECALL_MIN_S  2
`define FHR_RECALL_MAX_S  5
`define FHR_CLEAR_MIN_S   10
`define FHR_CLEAR_MAX_S   15
`define FHR_TICKS_PER_S   10
`define FHR_BLINK_TICKS   5
`define FHR_END_TICKS     30
`define FHR_SHOW88_TICKS  30
`define FHR_DEPTH         6
`define FHR_REPEAT_MAX    3
`define FHR_SEG_DASH      7'h40
`define FHR_SEG_OFF       7'h00
`define FHR_SEG_EIGHT     7'h7F
`endif

// >>> verif/fhr_btn_model.sv
// Service button model: holds the button for a given count.
// Assumes it is called at a falling edge of clk.
module fhr_btn_model (
  input  wire logic clk,    // System clock
  output logic      button  // High while pressed
);
  timeunit 1ns;
  timeprecision 1ns;
  initial button = 1'b0;
  // Released line is low, as on the real switch
  task automatic press(input int n);
    button = 1'b1;
    repeat (n) @(negedge clk);
    button = 1'b0;
    repeat (12) @(negedge clk);
  endtask
endmodule // fhr_btn_model

// >>> verif/fhr_fault_history_recall_chk.sv
// Port checker for the fault history recall block.
// Assumes TICK_CYC 10 and DEB_CYC 2, so one tick is ten cycles.
module fhr_fault_history_recall_chk (
  input wire logic       clk,       // Clock
  input wire logic       rst_b,     // Reset, active low
  input wire logic       button_in, // Button
  input wire logic       demand_in, // Demand
  input wire logic [6:0] seg_hi_q,  // Tens digit
  input wire logic [6:0] seg_lo_q,  // Units digit
  input wire logic       standby    // Idle
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] hold_q;
  logic        arm_q;
  wire         dash  = seg_hi_q == 7'h40 && seg_lo_q == 7'h40;
  wire         blank = seg_hi_q == 7'h00 && seg_lo_q == 7'h00;
  wire         e88   = seg_hi_q == 7'h7F && seg_lo_q == 7'h7F;
  // Press length in cycles; arm_q notes a press begun in standby
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      hold_q <= 12'h000;
      arm_q  <= 1'b0;
    end
    else
    begin
      hold_q <= button_in ? hold_q + 12'h001 : 12'h000;
      if (button_in && hold_q == 12'h000)
        arm_q <= standby;
    end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_dash;
    button_in && arm_q && hold_q == 12'h0FA |-> dash;
  endproperty
  a_dash: assert property (p_dash) else $error("no dashes in recall hold");
  property p_demand;
    button_in && demand_in && hold_q == 12'h0FA |-> !dash;
  endproperty
  a_demand: assert property (p_demand) else $error("press taken under demand");
  // Half period is fifty cycles, so sixty covers either phase
  property p_blink;
    button_in && arm_q && hold_q == 12'h41A |-> ##[1:60] blank ##[1:60] dash;
  endproperty
  a_blink: assert property (p_blink) else $error("no blink in clear hold");
  property p_clear;
    !button_in && $past(button_in) && arm_q && $past(hold_q) >= 12'h41A
      && $past(hold_q) < 12'h5AA |-> ##[1:6] e88;
  endproperty
  a_clear: assert property (p_clear) else $error("no 88 after clear");
  property p_short;
    !button_in && $past(button_in) && arm_q && $past(hold_q) < 12'h096 |-> ##[3:8] standby;
  endproperty
  a_short: assert property (p_short) else $error("short hold left idle");
  property p_mid;
    !button_in && $past(button_in) && arm_q && $past(hold_q) >= 12'h258
      && $past(hold_q) < 12'h384 |-> ##[3:8] standby;
  endproperty
  a_mid: assert property (p_mid) else $error("middle hold left idle");
  property p_over;
    !button_in && $past(button_in) && arm_q && $past(hold_q) >= 12'h618
      |-> ##[3:8] standby && !e88;
  endproperty
  a_over: assert property (p_over) else $error("long hold not cancelled");
  property p_glitch;
    standby && !button_in ##1 button_in ##1 !button_in |-> standby;
  endproperty
  a_glitch: assert property (p_glitch) else $error("glitch taken as press");
endmodule // fhr_fault_history_recall_chk

// >>> verif/fhr_fault_history_recall_tb.sv
// Self-checking bench for the fault history recall block.
// Assumes short tick and debounce counts, set at the instance.
module fhr_fault_history_recall_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [127:0] SG = 128'h71795E397C776F7F077D6D664F5B063F;
  logic       clk, rst_b, button_in, demand_in, fault_log, standby;
  logic [7:0] active_fault;
  logic [6:0] seg_hi_q, seg_lo_q;
  int         err_total = 0, num_checks = 0;
  logic [7:0] hist [6] = '{8'h21, 8'h21, 8'h21, 8'h14, 8'h13, 8'h12};
  fhr_fault_history_recall #(.TICK_CYC(10), .DEB_CYC(2)) uut (.clk(clk), .rst_b(rst_b),
    .button_in(button_in), .demand_in(demand_in), .active_fault(active_fault),
    .fault_log(fault_log), .seg_hi_q(seg_hi_q), .seg_lo_q(seg_lo_q), .standby(standby));
  fhr_btn_model btn (.clk(clk), .button(button_in));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic see(input logic [7:0] c);
    chk(seg_hi_q === SG[c[7:4]*8 +: 7] && seg_lo_q === SG[c[3:0]*8 +: 7], "display");
  endtask
  task automatic wait_sb;
    repeat (500) if (standby !== 1'b1) @(negedge clk);
    chk(standby, "no standby");
  endtask
  task automatic log_code(input logic [7:0] c);
    active_fault = c;
    fault_log = 1'b1;
    @(negedge clk);
    fault_log = 1'b0;
    @(negedge clk);
  endtask
  // Opens recall, steps through n entries, then waits for the closing dashes
  task automatic recall_all(input int n);
    btn.press(300);
    for (int i = 0; i < n; i++)
    begin
      see(hist[i]);
      btn.press(30);
    end
    repeat (100) if (seg_hi_q !== 7'h40) @(negedge clk);
    chk(seg_hi_q === 7'h40, "no end dashes");
    wait_sb;
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict;
  end
  initial
  begin
    {rst_b, demand_in, fault_log} = 3'b000;
    active_fault = 8'h00;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    for (int i = 0; i < 8; i++) log_code(i < 4 ? 8'(8'h11 + i) : 8'h21);
    active_fault = 8'h5A;
    @(negedge clk);
    see(8'h5A);
    btn.press(1);
    see(8'h5A);
    btn.press(100);
    wait_sb;
    btn.press(700);
    wait_sb;
    demand_in = 1'b1;
    btn.press(300);
    see(8'h5A);
    demand_in = 1'b0;
    recall_all(6);
    btn.press(1600);
    wait_sb;
    recall_all(6);
    btn.press(1200);
    chk(seg_hi_q === 7'h7F && seg_lo_q === 7'h7F, "no 88");
    wait_sb;
    log_code(8'h00);
    recall_all(0);
    chk(seg_hi_q === 7'h00 && seg_lo_q === 7'h00, "display not off");
    // Mid-run reset: display must pick up the active code at once
    active_fault = 8'h5A;
    rst_b = 1'b0;
    @(negedge clk);
    chk(seg_hi_q === 7'h00 && seg_lo_q === 7'h00, "segments lit in reset");
    rst_b = 1'b1;
    @(negedge clk);
    see(8'h5A);
    give_verdict;
  end
endmodule // fhr_fault_history_recall_tb

bind fhr_fault_history_recall fhr_fault_history_recall_chk chk_i (.clk(clk), .rst_b(rst_b),
  .button_in(button_in), .demand_in(demand_in), .seg_hi_q(seg_hi_q), .seg_lo_q(seg_lo_q),
  .standby(standby));
